// >>> src/pfrl_pkg.sv
// Operation
// RULE1: Carry flag can be set, cleared or inverted; other flags untouched.
// RULE2: Direction flag can be forced to one or forced to zero.
// RULE3: String steps increment index registers when direction is zero, else decrement.
// RULE4: Maskable interrupt pin is serviced only while interrupt-enable flag is one.
// RULE5: Set and clear of interrupt-enable depend on mode and privilege level.
// RULE6: Flags-to-byte copies sign, zero, aux, parity, carry to bits 7,6,4,2,0.
// RULE7: Bits 5, 3 and 1 of that byte are undefined.
// RULE8: Byte-to-flags loads bits 7,6,4,2,0 into sign, zero, aux, parity, carry.
// RULE9: Word flag push places only the low sixteen flag bits.
// RULE10: Doubleword push places all flags with resume and virtual-8086 bits zero.
// RULE11: Word pop always updates bits 11,10,8,7,6,4,2,0 from the popped word.
// RULE12: Either pop writes privilege field bits 13:12 only at privilege level 0.
// RULE13: Either pop writes bit 9 only when privilege field >= current level.
// RULE14: Doubleword pop may also update bits 18 and 21.
// RULE15: Pipeline supplies privilege level and mode with each pop or interrupt op.
`default_nettype none
package pfrl_pkg;
  // Flag bit positions
  localparam int CARRY_BIT  = 0;
  localparam int PARITY_BIT = 2;
  localparam int AUX_BIT    = 4;
  localparam int ZERO_BIT   = 6;
  localparam int SIGN_BIT   = 7;
  localparam int IF_BIT     = 9;
  localparam int DIR_BIT    = 10;
  localparam int IOPRIV_LO  = 12;
  localparam int RESUME_BIT = 16;
  localparam int V86_BIT    = 17;
  localparam int ALIGN_BIT  = 18;
  localparam int PROBE_BIT  = 21;
  // Pop write masks and push masks
  localparam logic [31:0] POP_BASE_MASK    = 32'h0000_0DD5;
  localparam logic [31:0] POP_IOPRIV_MASK  = 32'h0000_3000;
  localparam logic [31:0] POP_IF_MASK    = 32'h0000_0200;
  localparam logic [31:0] POP_DWORD_MASK = 32'h0024_0000;
  localparam logic [31:0] PUSHD_CLR_MASK = 32'h0003_0000;
  localparam logic [31:0] WORD_MASK      = 32'h0000_FFFF;
  // Reset values
  localparam logic [31:0] FLAGS_RST = 32'h0000_0000;
  localparam logic [31:0] IDX_RST   = 32'h0000_0000;
  // Register offsets, top privilege level and highest I/O privilege value
  localparam logic [7:0] FLAGS_OFS   = 8'h00;
  localparam logic [7:0] SRC_IDX_OFS = 8'h04;
  localparam logic [7:0] DST_IDX_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS  = 8'h0C;
  localparam logic [1:0] PRIV_TOP    = 2'h0;
  localparam logic [1:0] IOPRIV_MAX  = 2'h3;

  typedef enum logic [1:0] {
    mode_real,
    mode_protected,
    mode_v86
  } pfrl_mode_e;

  typedef enum logic [3:0] {
    no_op,
    set_carry_op,
    clear_carry_op,
    invert_carry_op,
    set_direction_op,
    clear_direction_op,
    set_interrupt_op,
    clear_interrupt_op,
    flags_to_byte_op,
    byte_to_flags_op,
    push_flags_word_op,
    push_flags_dword_op,
    pop_flags_word_op,
    pop_flags_dword_op
  } pfrl_op_e;
endpackage
`default_nettype wire

// >>> src/pfrl_priv_if.sv
`timescale 1ns/1ns
`default_nettype none
interface pfrl_priv_if;
  import pfrl_pkg::*;
  logic [1:0]  cur_priv;
  logic [1:0]  io_priv;
  pfrl_mode_e  mode;
  logic        dword;
  logic [31:0] pop_mask;
  logic        if_op_ok;
  modport req  (output cur_priv, io_priv, mode, dword, input pop_mask, if_op_ok);
  modport calc (input cur_priv, io_priv, mode, dword, output pop_mask, if_op_ok);
endinterface
`default_nettype wire

// >>> src/pfrl_priv_calc.sv
`timescale 1ns/1ns
`default_nettype none
module pfrl_priv_calc
  import pfrl_pkg::*;
(
  pfrl_priv_if.calc pif
);
  // Pop write mask from width and privilege
  always_comb begin
    pif.pop_mask = POP_BASE_MASK;                             // RULE11
    if (pif.cur_priv == PRIV_TOP) begin
      pif.pop_mask = pif.pop_mask | POP_IOPRIV_MASK;          // RULE12
    end
    if (pif.io_priv >= pif.cur_priv) begin
      pif.pop_mask = pif.pop_mask | POP_IF_MASK;              // RULE13
    end
    if (pif.dword) begin
      pif.pop_mask = pif.pop_mask | POP_DWORD_MASK;           // RULE14
    end else begin
      pif.pop_mask = pif.pop_mask & WORD_MASK;
    end
  end

  // Permission for interrupt-enable set and clear
  always_comb begin
    if (pif.mode == mode_real) begin
      pif.if_op_ok = 1'b1;                                    // RULE5
    end else if (pif.mode == mode_v86) begin
      pif.if_op_ok = (pif.io_priv == IOPRIV_MAX);             // RULE5
    end else begin
      pif.if_op_ok = (pif.cur_priv <= pif.io_priv);           // RULE5
    end
  end
endmodule
`default_nettype wire

// >>> src/pfrl_flags_unit.sv
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module pfrl_flags_unit
  import pfrl_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        nrst,
  // Operation port from the pipeline
  input  wire logic        op_valid,
  input  wire pfrl_op_e    op_code,
  input  wire logic [1:0]  current_privilege_level,
  input  wire pfrl_mode_e  op_mode,
  input  wire logic [31:0] pop_data,
  input  wire logic [7:0]  accumulator_high_byte,
  output logic             op_done_q,
  output logic             priv_fault_q,
  output logic [31:0]      push_data_q,
  output logic [7:0]       byte_out_q,
  // String stepping
  input  wire logic        step_valid,
  input  wire logic [2:0]  step_bytes,
  output logic [31:0]      source_index_reg_q,
  output logic [31:0]      destination_index_reg_q,
  // Interrupt pin and flags register output
  input  wire logic        maskable_irq_pin,
  output logic             irq_service_q,
  output logic [31:0]      flags_register_q,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata_q
);
  pfrl_priv_if pif ();

  logic        irq_meta_q;
  logic        irq_sync_q;
  logic [31:0] flags_d;
  logic        fault_d;
  logic [31:0] step_ext;
  logic        is_if_op;
  logic        is_pop;

  // Privilege context for the mask calculator
  assign pif.cur_priv = current_privilege_level;              // RULE15
  assign pif.io_priv  = flags_register_q[IOPRIV_LO+1:IOPRIV_LO];
  assign pif.mode  = op_mode;
  assign pif.dword = (op_code == pop_flags_dword_op);

  pfrl_priv_calc u_calc (
    .pif (pif)
  );

  assign is_if_op = op_valid && (op_code == set_interrupt_op || op_code == clear_interrupt_op);
  assign is_pop   = op_valid && (op_code == pop_flags_word_op || op_code == pop_flags_dword_op);
  assign step_ext = {29'h0000_0000, step_bytes};

  // Next flags value; operations win over a register write
  always_comb begin
    flags_d = flags_register_q;
    fault_d = 1'b0;
    if (op_valid) begin
      case (op_code)
        set_carry_op: begin
          flags_d[CARRY_BIT] = 1'b1;                          // RULE1
        end
        clear_carry_op: begin
          flags_d[CARRY_BIT] = 1'b0;                          // RULE1
        end
        invert_carry_op: begin
          flags_d[CARRY_BIT] = ~flags_register_q[CARRY_BIT];  // RULE1
        end
        set_direction_op: begin
          flags_d[DIR_BIT] = 1'b1;                            // RULE2
        end
        clear_direction_op: begin
          flags_d[DIR_BIT] = 1'b0;                            // RULE2
        end
        set_interrupt_op, clear_interrupt_op: begin
          if (pif.if_op_ok) begin
            flags_d[IF_BIT] = (op_code == set_interrupt_op);  // RULE5
          end else begin
            fault_d = 1'b1;                                   // RULE5
          end
        end
        byte_to_flags_op: begin
          flags_d[SIGN_BIT]   = accumulator_high_byte[7];     // RULE8
          flags_d[ZERO_BIT]   = accumulator_high_byte[6];
          flags_d[AUX_BIT]    = accumulator_high_byte[4];
          flags_d[PARITY_BIT] = accumulator_high_byte[2];
          flags_d[CARRY_BIT]  = accumulator_high_byte[0];
        end
        pop_flags_word_op, pop_flags_dword_op: begin
          flags_d = (flags_register_q & ~pif.pop_mask) | (pop_data & pif.pop_mask);  // RULE11
        end
        default: begin
          flags_d = flags_register_q;                         // RULE6
        end
      endcase
    end else if (reg_wr && reg_addr == FLAGS_OFS) begin
      flags_d = reg_wdata;
    end
  end

  // Flags register
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      flags_register_q <= FLAGS_RST;
    end else begin
      flags_register_q <= flags_d;
    end
  end

  // Operation results
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      op_done_q    <= 1'b0;
      priv_fault_q <= 1'b0;
      push_data_q  <= 32'h0000_0000;
      byte_out_q   <= 8'h00;
    end else begin
      op_done_q    <= op_valid && (op_code != no_op);
      priv_fault_q <= fault_d;
      if (op_valid && op_code == push_flags_word_op) begin
        push_data_q <= flags_register_q & WORD_MASK;          // RULE9
      end else if (op_valid && op_code == push_flags_dword_op) begin
        push_data_q <= flags_register_q & ~PUSHD_CLR_MASK;    // RULE10
      end
      if (op_valid && op_code == flags_to_byte_op) begin
        // Undefined positions are driven as zero
        byte_out_q <= {flags_register_q[SIGN_BIT], flags_register_q[ZERO_BIT], 1'b0,  // RULE7
                       flags_register_q[AUX_BIT], 1'b0, flags_register_q[PARITY_BIT],
                       1'b0, flags_register_q[CARRY_BIT]};    // RULE6
      end
    end
  end

  // Index registers stepped by direction flag
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      source_index_reg_q      <= IDX_RST;
      destination_index_reg_q <= IDX_RST;
    end else if (step_valid) begin
      if (!flags_register_q[DIR_BIT]) begin
        source_index_reg_q      <= source_index_reg_q + step_ext;       // RULE3
        destination_index_reg_q <= destination_index_reg_q + step_ext;
      end else begin
        source_index_reg_q      <= source_index_reg_q - step_ext;       // RULE3
        destination_index_reg_q <= destination_index_reg_q - step_ext;
      end
    end else if (reg_wr && reg_addr == SRC_IDX_OFS) begin
      source_index_reg_q <= reg_wdata;
    end else if (reg_wr && reg_addr == DST_IDX_OFS) begin
      destination_index_reg_q <= reg_wdata;
    end
  end

  // Interrupt pin synchroniser and gate
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irq_meta_q    <= 1'b0;
      irq_sync_q    <= 1'b0;
      irq_service_q <= 1'b0;
    end else begin
      irq_meta_q    <= maskable_irq_pin;
      irq_sync_q    <= irq_meta_q;
      irq_service_q <= irq_sync_q & flags_register_q[IF_BIT];  // RULE4
    end
  end

  // Register read port, data valid one cycle after strobe
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata_q <= 32'h0000_0000;
    end else if (!reg_rd) begin
      reg_rdata_q <= 32'h0000_0000;
    end else if (reg_addr == FLAGS_OFS) begin
      reg_rdata_q <= flags_register_q;
    end else if (reg_addr == SRC_IDX_OFS) begin
      reg_rdata_q <= source_index_reg_q;
    end else if (reg_addr == DST_IDX_OFS) begin
      reg_rdata_q <= destination_index_reg_q;
    end else if (reg_addr == STATUS_OFS) begin
      reg_rdata_q <= {30'h0000_0000, priv_fault_q, irq_service_q};
    end else begin
      reg_rdata_q <= 32'h0000_0000;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  // One operation of a given kind
  sequence s_op(pfrl_op_e c);
    op_valid && op_code == c;
  endsequence

  // Either pop width
  sequence s_pop;
    op_valid && (op_code == pop_flags_word_op || op_code == pop_flags_dword_op);
  endsequence

  // Interrupt-enable operation that mode and level allow
  sequence s_if_ok(pfrl_op_e c);
    op_valid && op_code == c && pif.if_op_ok;
  endsequence

  // String step in the given direction
  sequence s_step(logic down);
    step_valid && flags_register_q[DIR_BIT] == down;
  endsequence

  // Carry and direction operations
  carry_set_a: assert property (s_op(set_carry_op)  // RULE1
    |=> flags_register_q == ($past(flags_register_q) | 32'h0000_0001))
    else $error("carry set changed wrong bits");
  carry_clear_a: assert property (s_op(clear_carry_op)  // RULE1
    |=> flags_register_q == ($past(flags_register_q) & 32'hFFFF_FFFE))
    else $error("carry clear changed wrong bits");
  carry_invert_a: assert property (s_op(invert_carry_op)  // RULE1
    |=> (flags_register_q ^ $past(flags_register_q)) == 32'h0000_0001)
    else $error("carry invert wrong");
  dir_set_a: assert property (s_op(set_direction_op)  // RULE2
    |=> flags_register_q == ($past(flags_register_q) | 32'h0000_0400))
    else $error("direction set changed wrong bits");
  dir_clear_a: assert property (s_op(clear_direction_op)  // RULE2
    |=> !flags_register_q[DIR_BIT])
    else $error("direction not cleared");

  // Index stepping
  index_inc_a: assert property (s_step(1'b0)  // RULE3
    |=> source_index_reg_q == $past(source_index_reg_q) + $past(step_ext))
    else $error("index did not increment");
  index_step_a: assert property (s_step(1'b1)  // RULE3
    |=> source_index_reg_q == $past(source_index_reg_q) - $past(step_ext))
    else $error("index did not decrement");
  dst_step_a: assert property (s_step(1'b1)  // RULE3
    |=> destination_index_reg_q == $past(destination_index_reg_q) - $past(step_ext))
    else $error("destination index did not decrement");

  // Interrupt gate and permission
  irq_gate_a: assert property (irq_service_q  // RULE4
    |-> $past(flags_register_q[IF_BIT]) && $past(irq_sync_q))
    else $error("masked interrupt serviced");
  irq_mask_a: assert property (!flags_register_q[IF_BIT]  // RULE4
    |=> !irq_service_q)
    else $error("interrupt passed while disabled");
  irq_pass_a: assert property (flags_register_q[IF_BIT] && irq_sync_q  // RULE4
    |=> irq_service_q)
    else $error("enabled interrupt not serviced");
  if_set_a: assert property (s_if_ok(set_interrupt_op)  // RULE5
    |=> flags_register_q[IF_BIT] && !priv_fault_q)
    else $error("permitted interrupt set failed");
  if_clear_a: assert property (s_if_ok(clear_interrupt_op)  // RULE5
    |=> !flags_register_q[IF_BIT] && !priv_fault_q)
    else $error("permitted interrupt clear failed");
  if_refuse_a: assert property (is_if_op && !pif.if_op_ok  // RULE5
    |=> priv_fault_q && $stable(flags_register_q[IF_BIT]))
    else $error("refused interrupt op changed flag");
  fault_cause_a: assert property (priv_fault_q  // RULE5
    |-> $past(is_if_op))
    else $error("fault without interrupt op");

  // Byte copies
  byte_copy_a: assert property (s_op(flags_to_byte_op)  // RULE6
    |=> byte_out_q[7] == $past(flags_register_q[SIGN_BIT]) && byte_out_q[0] == $past(flags_register_q[CARRY_BIT])
        && $stable(flags_register_q))
    else $error("flags to byte copy wrong");
  byte_rest_a: assert property (s_op(flags_to_byte_op)  // RULE6
    |=> byte_out_q[6] == $past(flags_register_q[ZERO_BIT]) && byte_out_q[4] == $past(flags_register_q[AUX_BIT])
        && byte_out_q[2] == $past(flags_register_q[PARITY_BIT]))
    else $error("flags to byte middle bits wrong");
  byte_load_a: assert property (s_op(byte_to_flags_op)  // RULE8
    |=> flags_register_q[ZERO_BIT] == $past(accumulator_high_byte[6])
        && flags_register_q[AUX_BIT] == $past(accumulator_high_byte[4])
        && flags_register_q[SIGN_BIT] == $past(accumulator_high_byte[7])
        && flags_register_q[CARRY_BIT] == $past(accumulator_high_byte[0]))
    else $error("byte to flags load wrong");
  byte_keep_a: assert property (s_op(byte_to_flags_op)  // RULE8
    |=> ((flags_register_q ^ $past(flags_register_q)) & 32'hFFFF_FF2A) == 32'h0000_0000)
    else $error("byte to flags touched other bits");

  // Pushes
  push_word_a: assert property (s_op(push_flags_word_op)  // RULE9
    |=> push_data_q[31:16] == 16'h0000)
    else $error("word push carries high bits");
  push_low_a: assert property (s_op(push_flags_word_op)  // RULE9
    |=> push_data_q[15:0] == $past(flags_register_q[15:0]))
    else $error("word push low bits wrong");
  push_dword_a: assert property (s_op(push_flags_dword_op)  // RULE10
    |=> !push_data_q[RESUME_BIT] && !push_data_q[V86_BIT] && push_data_q[15:0] == $past(flags_register_q[15:0]))
    else $error("dword push shows resume or v86");

  // Pops
  pop_io_privilege_field_a: assert property (s_pop and current_privilege_level != PRIV_TOP  // RULE12
    |=> $stable(flags_register_q[IOPRIV_LO+1:IOPRIV_LO]))
    else $error("privilege field written above level 0");
  pop_level0_a: assert property (s_pop and current_privilege_level == PRIV_TOP  // RULE12
    |=> flags_register_q[IOPRIV_LO+1:IOPRIV_LO] == $past(pop_data[IOPRIV_LO+1:IOPRIV_LO]))
    else $error("privilege field not written at level 0");
  pop_if_a: assert property (s_pop and flags_register_q[IOPRIV_LO+1:IOPRIV_LO] < current_privilege_level  // RULE13
    |=> $stable(flags_register_q[IF_BIT]))
    else $error("interrupt flag popped without privilege");
  pop_if_ok_a: assert property (s_pop and flags_register_q[IOPRIV_LO+1:IOPRIV_LO] >= current_privilege_level  // RULE13
    |=> flags_register_q[IF_BIT] == $past(pop_data[IF_BIT]))
    else $error("interrupt flag not popped with privilege");
  pop_word_a: assert property (s_op(pop_flags_word_op)  // RULE11
    |=> flags_register_q[CARRY_BIT] == $past(pop_data[0]) && $stable(flags_register_q[31:16]))
    else $error("word pop mask wrong");
  pop_keep_a: assert property (s_pop  // RULE11
    |=> ((flags_register_q ^ $past(flags_register_q))
         & ~(POP_BASE_MASK | POP_IOPRIV_MASK | POP_IF_MASK | POP_DWORD_MASK)) == 32'h0000_0000)
    else $error("pop changed a protected bit");
  pop_dword_a: assert property (s_op(pop_flags_dword_op)  // RULE14
    |=> flags_register_q[PROBE_BIT] == $past(pop_data[PROBE_BIT]))
    else $error("dword pop missed bit 21");
  pop_align_a: assert property (s_op(pop_flags_dword_op)  // RULE14
    |=> flags_register_q[ALIGN_BIT] == $past(pop_data[ALIGN_BIT]))
    else $error("dword pop missed bit 18");
endmodule
`default_nettype wire

// >>> test/pfrl_pipe_model.sv
`timescale 1ns/1ns
`default_nettype none
module pfrl_pipe_model
  import pfrl_pkg::*;
(
  input  wire logic   mclk,
  output logic        op_valid,
  output var pfrl_op_e op_code,
  output logic [1:0]  priv_lvl,
  output var pfrl_mode_e op_mode,
  output logic [31:0] pop_data,
  output logic [7:0]  acc_byte,
  output logic        step_valid,
  output logic [2:0]  step_bytes
);
  // Idle pipeline at time zero
  initial begin
    op_valid   = 1'b0;
    op_code    = no_op;
    priv_lvl   = 2'h0;
    op_mode    = mode_real;
    pop_data   = 32'h0;
    acc_byte   = 8'h0;
    step_valid = 1'b0;
    step_bytes = 3'h1;
  end
  // One operation, level and mode travel with it
  task automatic issue(input pfrl_op_e op, input logic [1:0] lvl, input pfrl_mode_e md,
                       input logic [31:0] data, input logic [7:0] acc);
    @(posedge mclk);
    op_valid <= 1'b1;
    op_code  <= op;
    priv_lvl <= lvl;
    op_mode  <= md;
    pop_data <= data;
    acc_byte <= acc;
    @(posedge mclk);
    op_valid <= 1'b0;
    pop_data <= ~data;
    acc_byte <= ~acc;
    #1;
  endtask
  // One string element step
  task automatic step(input logic [2:0] n);
    @(posedge mclk);
    step_valid <= 1'b1;
    step_bytes <= n;
    @(posedge mclk);
    step_valid <= 1'b0;
    #1;
  endtask
endmodule
`default_nettype wire

// >>> test/processor_flags_register_logic_tb.sv
`timescale 1ns/1ns
`default_nettype none
module processor_flags_register_logic_tb;
  import pfrl_pkg::*;
  logic        mclk, nrst, irq_pin, reg_wr, reg_rd;
  logic        op_valid, step_valid, op_done_q, priv_fault_q, irq_service_q;
  pfrl_op_e    op_code;
  pfrl_mode_e  op_mode;
  logic [1:0]  priv_lvl;
  logic [2:0]  step_bytes;
  logic [7:0]  acc_byte, byte_out_q, reg_addr;
  logic [31:0] pop_data, push_data_q, src_q, dst_q, flags_q, reg_wdata, reg_rdata_q, v;
  int          err_count, samples_checked;
  pfrl_op_e    ops[5];
  logic [1:0]  lvls[5];
  logic [31:0] pdat[5], e;

  pfrl_pipe_model pipe (.mclk(mclk), .op_valid(op_valid), .op_code(op_code), .priv_lvl(priv_lvl),
    .op_mode(op_mode), .pop_data(pop_data), .acc_byte(acc_byte), .step_valid(step_valid),
    .step_bytes(step_bytes));
  pfrl_flags_unit uut (.mclk(mclk), .nrst(nrst), .op_valid(op_valid), .op_code(op_code),
    .current_privilege_level(priv_lvl), .op_mode(op_mode), .pop_data(pop_data),
    .accumulator_high_byte(acc_byte), .op_done_q(op_done_q), .priv_fault_q(priv_fault_q),
    .push_data_q(push_data_q), .byte_out_q(byte_out_q), .step_valid(step_valid),
    .step_bytes(step_bytes), .source_index_reg_q(src_q), .destination_index_reg_q(dst_q),
    .maskable_irq_pin(irq_pin), .irq_service_q(irq_service_q), .flags_register_q(flags_q),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q));

  // Clock
  always #20 mclk = ~mclk;
  // Compare and count
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask
  // Register read, data taken the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata_q;
  endtask
  // Expected flags after a pop
  function automatic logic [31:0] exp_pop(logic [31:0] old, logic [31:0] d, logic [1:0] l,
                                          logic dw);
    logic [31:0] m;
    m = POP_BASE_MASK | (l == 2'h0 ? POP_IOPRIV_MASK : 32'h0);
    m = m | (old[13:12] >= l ? POP_IF_MASK : 32'h0) | (dw ? POP_DWORD_MASK : 32'h0);
    return (old & ~m) | (d & m);
  endfunction
  // Verdict
  task automatic report_and_stop;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    #200000;
    err_count++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    mclk = 1'b0; nrst = 1'b0; irq_pin = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0;
    reg_addr = 8'h00; reg_wdata = 32'h0; err_count = 0; samples_checked = 0;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    rd(FLAGS_OFS, v); check("flags_rst", v, FLAGS_RST);
    rd(SRC_IDX_OFS, v); check("src_rst", v, IDX_RST);
    rd(8'h10, v); check("unmapped", v, 32'h0);
    // Carry ops leave the other bits alone
    wr(FLAGS_OFS, 32'h0000_3000);
    ops = '{set_carry_op, invert_carry_op, invert_carry_op, clear_carry_op, no_op};
    for (int i = 0; i < 4; i++) begin
      pipe.issue(ops[i], 2'h0, mode_real, 32'h0, 8'h0);
      check("carry", flags_q, {31'h1800, ~i[0]});
      check("done", {31'h0, op_done_q}, 32'h1);
    end
    // Direction and string stepping
    wr(SRC_IDX_OFS, 32'h0000_0100);
    wr(DST_IDX_OFS, 32'h0000_0200);
    pipe.issue(set_direction_op, 2'h0, mode_real, 32'h0, 8'h0);
    check("dir_set", flags_q, 32'h0000_3400);
    pipe.step(3'h4);
    check("src_dec", src_q, 32'h0000_00FC);
    check("dst_dec", dst_q, 32'h0000_01FC);
    pipe.issue(clear_direction_op, 2'h0, mode_real, 32'h0, 8'h0);
    check("dir_clr", flags_q, 32'h0000_3000);
    pipe.step(3'h2);
    check("src_inc", src_q, 32'h0000_00FE);
    check("dst_inc", dst_q, 32'h0000_01FE);
    // Interrupt enable, permission and masking
    pipe.issue(set_interrupt_op, 2'h3, mode_protected, 32'h0, 8'h0);
    check("if_set", flags_q, 32'h0000_3200);
    @(posedge mclk);
    irq_pin <= 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    check("irq_on", {31'h0, irq_service_q}, 32'h1);
    rd(STATUS_OFS, v); check("status", v, 32'h1);
    wr(FLAGS_OFS, 32'h0000_0200);
    pipe.issue(clear_interrupt_op, 2'h1, mode_protected, 32'h0, 8'h0);
    check("fault_prot", {31'h0, priv_fault_q}, 32'h1);
    pipe.issue(clear_interrupt_op, 2'h0, mode_v86, 32'h0, 8'h0);
    check("fault_v86", {31'h0, priv_fault_q}, 32'h1);
    check("if_kept", flags_q, 32'h0000_0200);
    pipe.issue(clear_interrupt_op, 2'h3, mode_real, 32'h0, 8'h0);
    check("if_clr", flags_q, 32'h0);
    repeat (4) @(posedge mclk);
    #1;
    check("irq_off", {31'h0, irq_service_q}, 32'h0);
    @(posedge mclk);
    irq_pin <= 1'b0;
    // Byte copies
    wr(FLAGS_OFS, 32'h0000_0095);
    pipe.issue(flags_to_byte_op, 2'h0, mode_real, 32'h0, 8'h0);
    check("to_byte", {24'h0, byte_out_q & 8'hD5}, 32'h95);
    check("to_byte_fl", flags_q, 32'h0000_0095);
    pipe.issue(byte_to_flags_op, 2'h0, mode_real, 32'h0, 8'h6A);
    check("from_byte", flags_q, 32'h0000_0040);
    // Pushes
    wr(FLAGS_OFS, 32'hFFFF_FFFF);
    pipe.issue(push_flags_word_op, 2'h0, mode_real, 32'h0, 8'h0);
    check("push_w", push_data_q, 32'h0000_FFFF);
    pipe.issue(push_flags_dword_op, 2'h0, mode_real, 32'h0, 8'h0);
    check("push_d", push_data_q, 32'hFFFC_FFFF);
    // Pops under several privilege levels
    wr(FLAGS_OFS, 32'h0);
    e = 32'h0;
    ops = '{pop_flags_word_op, pop_flags_word_op, pop_flags_dword_op, pop_flags_dword_op,
            pop_flags_word_op};
    lvls = '{2'h3, 2'h0, 2'h1, 2'h0, 2'h0};
    pdat = '{32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0, 32'hFFFF_FFFF, 32'h0};
    for (int i = 0; i < 5; i++) begin
      pipe.issue(ops[i], lvls[i], mode_protected, pdat[i], 8'h0);
      e = exp_pop(e, pdat[i], lvls[i], ops[i] == pop_flags_dword_op);
      check("pop", flags_q, e);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
